// >>> verilog/oioe_defs.vh
`ifndef OIOE_DEFS_VH
`define OIOE_DEFS_VH

// register offsets, serial interface address space
`define OIOE_REG_DIR        8'h00
`define OIOE_REG_INV        8'h01
`define OIOE_REG_IRQEN      8'h02
`define OIOE_REG_COMPARE_DEFAULT_REG     8'h03
`define OIOE_REG_CMPSEL     8'h04
`define OIOE_REG_CFG        8'h05
`define OIOE_REG_PULLUP     8'h06
`define OIOE_REG_FLAG       8'h07
`define OIOE_REG_CAPTURE    8'h08
`define OIOE_REG_PORT       8'h09
`define OIOE_REG_LATCH      8'h0a
`define OIOE_REG_LAST       8'h0a

// reset values
`define OIOE_RST_DIR        8'hff
`define OIOE_RST_ZERO       8'h00

// configuration register field positions
`define OIOE_CFG_SEQ_OFF    5
`define OIOE_CFG_SLEW_OFF   4
`define OIOE_CFG_ADDR_EN    3
`define OIOE_CFG_OPEN_DRAIN 2
`define OIOE_CFG_IRQ_POL    1
`define OIOE_CFG_MASK       8'h3e

// control byte fixed part
`define OIOE_CTRL_FIXED5    5'h08
`define OIOE_CTRL_FIXED4    4'h4

// serial clock limit
`define OIOE_SCK_MAX_MHZ    10
`define OIOE_CLK_MHZ        100

`endif

// >>> verilog/oioe_spi_slave.v
`include "oioe_defs.vh"
`default_nettype none

module oioe_spi_slave (
    input  wire       clk_i,
    input  wire       sys_rst_i,
    input  wire       sck_i,
    input  wire       cs_n_i,
    input  wire       si_i,
    input  wire [7:0] tx_byte_i,
    output wire       frame_start_o,
    output wire       selected_o,
    output reg  [7:0] rx_byte_o,
    output reg        rx_valid_o,
    output reg        tx_load_o,
    output wire       so_o,
    output reg        too_fast_o
);

////////////////////////////////////////////////////////////////////////////////
// half the shortest legal serial clock period, in system clocks
localparam integer HALF_CYC = (`OIOE_CLK_MHZ / `OIOE_SCK_MAX_MHZ) / 2;

reg [1:0] sck_sync;
reg [1:0] cs_sync;
reg [1:0] si_sync;
reg       sck_d;
reg       cs_d;
reg [2:0] bit_cnt;
reg [6:0] rx_shift;
reg [7:0] tx_shift;
reg [7:0] gap_cnt;

wire sck_rise = sck_sync[1] & ~sck_d;
wire sck_fall = ~sck_sync[1] & sck_d;
wire active   = ~cs_sync[1];

assign frame_start_o = ~cs_sync[1] & cs_d;
assign selected_o    = active;
assign so_o          = tx_shift[7];

////////////////////////////////////////////////////////////////////////////////
always @(posedge clk_i) begin
    if (sys_rst_i) begin
        sck_sync <= 2'h0;
        cs_sync  <= 2'h3;
        si_sync  <= 2'h0;
        sck_d    <= 1'b0;
        cs_d     <= 1'b1;
    end else begin
        sck_sync <= {sck_sync[0], sck_i};
        cs_sync  <= {cs_sync[0], cs_n_i};
        si_sync  <= {si_sync[0], si_i};
        sck_d    <= sck_sync[1];
        cs_d     <= cs_sync[1];
    end
end

always @(posedge clk_i) begin
    if (sys_rst_i) begin
        bit_cnt    <= 3'h0;
        rx_shift   <= 7'h00;
        rx_byte_o  <= 8'h00;
        rx_valid_o <= 1'b0;
        tx_load_o  <= 1'b0;
        tx_shift   <= 8'h00;
        gap_cnt    <= 8'h00;
        too_fast_o <= 1'b0;
    end else begin
        rx_valid_o <= 1'b0;
        tx_load_o  <= 1'b0;
        if (gap_cnt != 8'hff)
            gap_cnt <= gap_cnt + 8'h01;
        if (frame_start_o) begin
            bit_cnt   <= 3'h0;
            tx_shift  <= tx_byte_i;
            tx_load_o <= 1'b1;
            gap_cnt   <= 8'h00;
        end else if (active && sck_rise) begin
            gap_cnt  <= 8'h00;
            rx_shift <= {rx_shift[5:0], si_sync[1]};
            bit_cnt  <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
                rx_byte_o  <= {rx_shift, si_sync[1]};
                rx_valid_o <= 1'b1;
            end
        end else if (active && sck_fall) begin
            gap_cnt <= 8'h00;
            // next byte goes out on the falling edge after the eighth bit
            if (bit_cnt == 3'h0) begin
                tx_shift  <= tx_byte_i;
                tx_load_o <= 1'b1;
            end else begin
                tx_shift <= {tx_shift[6:0], 1'b0};
            end
        end
        // sticky flag: master clocked faster than the allowed rate
        if (active && (sck_rise || sck_fall) && (gap_cnt < HALF_CYC[7:0] - 8'h1))
            too_fast_o <= 1'b1;
    end
end

endmodule // oioe_spi_slave

`default_nettype wire

// >>> verilog/oioe_core.v
// Operation
// - after any reset all eight pins are inputs, drivers off
// - master picks input or output per pin through direction bits
// - sampled inputs and output latch kept in per-bit storage
// - invert bit flips the reported input bit when set
// - every register readable by the master
// - change mode: interrupt when enabled input differs from previous state
// - compare mode: interrupt when enabled input differs from default; exclusive per pin
// - capture whole port value when interrupt occurs
// - interrupt pin active-high, active-low push-pull or open-drain
// - per pin interrupt enable and weak pull-up enable, independent
// - power-on reset loads defaults and resets the state machine
// - three address pins into slave address, eight devices per bus
// - two address pins into address match, four devices per select
// - serial clock at most 10 MHz; master keeps to it
// - eleven byte registers at consecutive addresses via serial interface
// - direction bit set means input, clear means output
// - port write updates latch; port read returns pin levels
// - input pins have output driver disabled, high impedance
`include "oioe_defs.vh"
`default_nettype none

module oioe_core #(
    parameter WIDTH = 8
) (
    input  wire             clk_i,
    input  wire             sys_rst_i,
    input  wire             ext_rst_n_i,
    input  wire             sck_i,
    input  wire             cs_n_i,
    input  wire             si_i,
    output wire             so_o,
    output wire             so_oe_o,
    input  wire             hw_addr_0_i,
    input  wire             hw_addr_1_i,
    input  wire             hw_addr_2_i,
    input  wire             addr3_mode_i,
    input  wire [WIDTH-1:0] port_pin_i,
    output wire [WIDTH-1:0] port_pin_o,
    output wire [WIDTH-1:0] port_pin_oe_o,
    output wire [WIDTH-1:0] pullup_en_o,
    output wire             irq_o,
    output wire             irq_oe_o,
    output wire             sck_too_fast_o
);

////////////////////////////////////////////////////////////////////////////////
localparam ST_CTRL = 2'h0;
localparam ST_ADDR = 2'h1;
localparam ST_DATA = 2'h2;
localparam ST_SKIP = 2'h3;

// registers
reg [WIDTH-1:0] pin_direction_reg;
reg [WIDTH-1:0] input_invert_reg;
reg [WIDTH-1:0] change_irq_enable_reg;
reg [WIDTH-1:0] compare_default_reg;
reg [WIDTH-1:0] irq_compare_select_reg;
reg [7:0]       cfg_reg;
reg [WIDTH-1:0] weak_pullup_reg;
reg [WIDTH-1:0] irq_flag_reg;
reg [WIDTH-1:0] irq_capture_reg;
reg [WIDTH-1:0] output_latch_reg;

// pin sampling and reset
reg [1:0]       ext_rst_sync;
reg [WIDTH-1:0] pin_sync1;
reg [WIDTH-1:0] pin_sync2;
reg [WIDTH-1:0] pin_prev;
reg [2:0]       hw_addr_sync1;
reg [2:0]       hw_addr_sync2;
reg             addr3_sync1;
reg             addr3_sync2;

// serial state
reg [1:0]       state;
reg [1:0]       next_state;
reg             rd_mode;
reg [7:0]       ptr;
reg [7:0]       tx_byte;

wire             core_rst;
wire             frame_start;
wire             selected;
wire [7:0]       rx_byte;
wire             rx_valid;
wire             tx_load;
wire [WIDTH-1:0] port_val;
wire [WIDTH-1:0] cmp_hit;
wire [WIDTH-1:0] chg_hit;
wire [WIDTH-1:0] irq_cause;
wire             irq_event;
wire             irq_active;
wire             ctrl_match;
wire             data_wr;
wire             rd_clear;

////////////////////////////////////////////////////////////////////////////////
// reset: the external pin goes through two flops, then joins system reset
always @(posedge clk_i) begin
    if (sys_rst_i) begin
        ext_rst_sync <= 2'h3;
    end else begin
        ext_rst_sync <= {ext_rst_sync[0], ~ext_rst_n_i};
    end
end

assign core_rst = sys_rst_i | ext_rst_sync[1];

////////////////////////////////////////////////////////////////////////////////
// pin and strap sampling
always @(posedge clk_i) begin
    if (core_rst) begin
        pin_sync1     <= {WIDTH{1'b0}};
        pin_sync2     <= {WIDTH{1'b0}};
        pin_prev      <= {WIDTH{1'b0}};
        hw_addr_sync1 <= 3'h0;
        hw_addr_sync2 <= 3'h0;
        addr3_sync1   <= 1'b0;
        addr3_sync2   <= 1'b0;
    end else begin
        pin_sync1     <= port_pin_i;
        pin_sync2     <= pin_sync1;
        pin_prev      <= pin_sync2;
        hw_addr_sync1 <= {hw_addr_2_i, hw_addr_1_i, hw_addr_0_i};
        hw_addr_sync2 <= hw_addr_sync1;
        addr3_sync1   <= addr3_mode_i;
        addr3_sync2   <= addr3_sync1;
    end
end

assign port_val = pin_sync2 ^ input_invert_reg;

////////////////////////////////////////////////////////////////////////////////
// serial engine
oioe_spi_slave u_spi (
    .clk_i         (clk_i),
    .sys_rst_i     (core_rst),
    .sck_i         (sck_i),
    .cs_n_i        (cs_n_i),
    .si_i          (si_i),
    .tx_byte_i     (tx_byte),
    .frame_start_o (frame_start),
    .selected_o    (selected),
    .rx_byte_o     (rx_byte),
    .rx_valid_o    (rx_valid),
    .tx_load_o     (tx_load),
    .so_o          (so_o),
    .too_fast_o    (sck_too_fast_o)
);

// strap selects a three-pin or two-pin address match
assign ctrl_match = addr3_sync2 ?
    (rx_byte[7:4] == `OIOE_CTRL_FIXED4) && (rx_byte[3:1] == hw_addr_sync2) :
    (rx_byte[7:3] == `OIOE_CTRL_FIXED5) && (rx_byte[2:1] == hw_addr_sync2[1:0]);

assign data_wr  = rx_valid && (state == ST_DATA) && !rd_mode;
// clear only once the byte has really been clocked out; the preload of the
// next byte and a stale state at the next select must not clear
assign rd_clear = rx_valid && (state == ST_DATA) && rd_mode &&
                  ((ptr == `OIOE_REG_CAPTURE) || (ptr == `OIOE_REG_PORT));
assign so_oe_o  = selected && rd_mode && (state == ST_DATA);

always @* begin
    next_state = state;
    if (frame_start) begin
        next_state = ST_CTRL;
    end else if (rx_valid) begin
        case (state)
            ST_CTRL: next_state = ctrl_match ? ST_ADDR : ST_SKIP;
            ST_ADDR: next_state = ST_DATA;
            default: next_state = state;
        endcase
    end
end

function [7:0] next_ptr;
    input [7:0] cur;
    input       seq_off;
    begin
        if (seq_off)
            next_ptr = cur;
        else if (cur >= `OIOE_REG_LAST)
            next_ptr = 8'h00;
        else
            next_ptr = cur + 8'h01;
    end
endfunction

always @(posedge clk_i) begin
    if (core_rst) begin
        state   <= ST_CTRL;
        rd_mode <= 1'b0;
        ptr     <= 8'h00;
    end else begin
        state <= next_state;
        if (rx_valid && state == ST_CTRL)
            rd_mode <= rx_byte[0];
        if (rx_valid && state == ST_ADDR)
            ptr <= rx_byte;
        else if (rx_valid && state == ST_DATA)
            ptr <= next_ptr(ptr, cfg_reg[`OIOE_CFG_SEQ_OFF]);
    end
end

////////////////////////////////////////////////////////////////////////////////
// read mux, every register visible
always @* begin
    if (ptr == `OIOE_REG_DIR)
        tx_byte = pin_direction_reg;
    else if (ptr == `OIOE_REG_INV)
        tx_byte = input_invert_reg;
    else if (ptr == `OIOE_REG_IRQEN)
        tx_byte = change_irq_enable_reg;
    else if (ptr == `OIOE_REG_COMPARE_DEFAULT_REG)
        tx_byte = compare_default_reg;
    else if (ptr == `OIOE_REG_CMPSEL)
        tx_byte = irq_compare_select_reg;
    else if (ptr == `OIOE_REG_CFG)
        tx_byte = cfg_reg;
    else if (ptr == `OIOE_REG_PULLUP)
        tx_byte = weak_pullup_reg;
    else if (ptr == `OIOE_REG_FLAG)
        tx_byte = irq_flag_reg;
    else if (ptr == `OIOE_REG_CAPTURE)
        tx_byte = irq_capture_reg;
    else if (ptr == `OIOE_REG_PORT)
        tx_byte = port_val;
    else if (ptr == `OIOE_REG_LATCH)
        tx_byte = output_latch_reg;
    else
        tx_byte = 8'h00;
end

////////////////////////////////////////////////////////////////////////////////
// register writes; flag and capture registers are read-only
always @(posedge clk_i) begin
    if (core_rst) begin
        pin_direction_reg      <= `OIOE_RST_DIR;
        input_invert_reg       <= `OIOE_RST_ZERO;
        change_irq_enable_reg  <= `OIOE_RST_ZERO;
        compare_default_reg    <= `OIOE_RST_ZERO;
        irq_compare_select_reg <= `OIOE_RST_ZERO;
        cfg_reg                <= `OIOE_RST_ZERO;
        weak_pullup_reg        <= `OIOE_RST_ZERO;
        output_latch_reg       <= `OIOE_RST_ZERO;
    end else if (data_wr) begin
        if (ptr == `OIOE_REG_DIR)
            pin_direction_reg <= rx_byte;
        else if (ptr == `OIOE_REG_INV)
            input_invert_reg <= rx_byte;
        else if (ptr == `OIOE_REG_IRQEN)
            change_irq_enable_reg <= rx_byte;
        else if (ptr == `OIOE_REG_COMPARE_DEFAULT_REG)
            compare_default_reg <= rx_byte;
        else if (ptr == `OIOE_REG_CMPSEL)
            irq_compare_select_reg <= rx_byte;
        else if (ptr == `OIOE_REG_CFG)
            cfg_reg <= rx_byte & `OIOE_CFG_MASK;
        else if (ptr == `OIOE_REG_PULLUP)
            weak_pullup_reg <= rx_byte;
        else if (ptr == `OIOE_REG_PORT || ptr == `OIOE_REG_LATCH)
            output_latch_reg <= rx_byte;
    end
end

////////////////////////////////////////////////////////////////////////////////
// pin drivers: set direction bit means input, driver off
assign port_pin_o    = output_latch_reg;
assign port_pin_oe_o = ~pin_direction_reg;
assign pullup_en_o   = weak_pullup_reg;

////////////////////////////////////////////////////////////////////////////////
// interrupt sources; the select bit picks one mode per pin
assign chg_hit   = (pin_sync2 ^ pin_prev) & ~irq_compare_select_reg;
assign cmp_hit   = (port_val ^ compare_default_reg) & irq_compare_select_reg;
assign irq_cause = (chg_hit | cmp_hit) & change_irq_enable_reg & pin_direction_reg;
assign irq_event = (|irq_cause) && (irq_flag_reg == {WIDTH{1'b0}} || rd_clear);

// a new cause in the clearing cycle wins over the clear
always @(posedge clk_i) begin
    if (core_rst) begin
        irq_flag_reg    <= `OIOE_RST_ZERO;
        irq_capture_reg <= `OIOE_RST_ZERO;
    end else if (irq_event) begin
        irq_flag_reg    <= irq_cause;
        irq_capture_reg <= port_val;
    end else if (rd_clear) begin
        irq_flag_reg <= `OIOE_RST_ZERO;
    end
end

assign irq_active = |irq_flag_reg;

// open drain only pulls low; push-pull follows the polarity bit
assign irq_o    = cfg_reg[`OIOE_CFG_OPEN_DRAIN] ? 1'b0 :
                  (irq_active ~^ cfg_reg[`OIOE_CFG_IRQ_POL]);
assign irq_oe_o = cfg_reg[`OIOE_CFG_OPEN_DRAIN] ? irq_active : 1'b1;

endmodule // oioe_core

`default_nettype wire

// >>> tb/oioe_core_checker.sv
`default_nettype none
module oioe_core_checker #(
    parameter WIDTH = 8
) (
    input wire logic             clk_i,
    input wire logic             sys_rst_i,
    input wire logic             ext_rst_n_i,
    input wire logic             sck_i,
    input wire logic             cs_n_i,
    input wire logic [WIDTH-1:0] port_pin_i,
    input wire logic [WIDTH-1:0] port_pin_o,
    input wire logic [WIDTH-1:0] port_pin_oe_o,
    input wire logic [WIDTH-1:0] pullup_en_o,
    input wire logic             irq_o,
    input wire logic             irq_oe_o,
    input wire logic             so_o,
    input wire logic             so_oe_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] quiet;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    // no frame, no pin change, no reset: nothing may move the outputs
    always @(posedge clk_i) begin
        if (sys_rst_i || !cs_n_i || !ext_rst_n_i || $changed(port_pin_i)) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hf) begin
            quiet <= quiet + 4'h1;
        end
    end
    chk_rst_pins: assert property (
        $fell(sys_rst_i) |-> port_pin_oe_o == '0 && port_pin_o == '0)
        else $error("port not idle after reset");
    chk_rst_irq: assert property (
        $fell(sys_rst_i) |-> irq_o && irq_oe_o && pullup_en_o == '0)
        else $error("interrupt or pull-ups not idle after reset");
    chk_od_no_high: assert property (
        !irq_oe_o |-> !irq_o)
        else $error("released interrupt pin driven high");
    chk_irq_holds: assert property (
        quiet >= 4'h8 |-> $stable(irq_o) && $stable(irq_oe_o))
        else $error("interrupt pin moved with no cause");
    chk_dir_holds: assert property (
        quiet >= 4'h8 |-> $stable(port_pin_oe_o))
        else $error("pin drivers moved with no write");
    chk_latch_holds: assert property (
        quiet >= 4'h8 |-> $stable(port_pin_o) && $stable(pullup_en_o))
        else $error("latch or pull-ups moved with no write");
    chk_so_idle: assert property (
        cs_n_i [*6] |-> !so_oe_o)
        else $error("serial out driven while deselected");
    chk_so_steady: assert property (
        (sck_i && so_oe_o) [*4] |-> $stable(so_o))
        else $error("serial out changed while clock high");
endmodule // oioe_core_checker

bind oioe_core oioe_core_checker #(.WIDTH(WIDTH)) u_oioe_core_checker (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ext_rst_n_i(ext_rst_n_i),
    .sck_i(sck_i), .cs_n_i(cs_n_i), .port_pin_i(port_pin_i),
    .port_pin_o(port_pin_o), .port_pin_oe_o(port_pin_oe_o),
    .pullup_en_o(pullup_en_o), .irq_o(irq_o), .irq_oe_o(irq_oe_o),
    .so_o(so_o), .so_oe_o(so_oe_o)
);
`default_nettype wire

// >>> tb/oioe_spi_master.sv
`default_nettype none
module oioe_spi_master (
    output var logic sck_o,
    output var logic cs_n_o,
    output var logic si_o,
    input wire logic so_i,
    input wire logic so_oe_i
);
    timeunit 1ns;
    timeprecision 100ps;
    logic last_so = 1'b0;
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // mode 0 byte at 8 MHz, below the slave's ceiling
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si_o = tx[i];
            #62.5 sck_o = 1'b1;
            // a released line shows the opposite of its last bit
            rx[i] = so_oe_i ? so_i : ~last_so;
            last_so = rx[i];
            #62.5 sck_o = 1'b0;
        end
    endtask
    task automatic frame(input logic [7:0] ctl, input logic [7:0] adr,
                         input logic [7:0] wd, output logic [7:0] rd);
        cs_n_o = 1'b0;
        #125;
        xfer(ctl, rd);
        xfer(adr, rd);
        xfer(wd, rd);
        #62.5 cs_n_o = 1'b1;
        si_o = ~si_o;
        #250;
    endtask
endmodule // oioe_spi_master
`default_nettype wire

// >>> tb/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic       ext_rst_n_i = 1'b1;
    logic       addr3_mode_i = 1'b1;
    logic [2:0] hw_addr = 3'h5;
    logic [2:0] dev = 3'h5;
    logic [7:0] port_pin_i = 8'h00;
    logic [7:0] rd;
    wire        sck, cs_n, si, so, so_oe, irq_o, irq_oe_o, too_fast;
    wire  [7:0] port_pin_o, port_pin_oe_o, pullup_en_o;
    int         failures = 0;
    int         checks = 0;
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    oioe_spi_master u_oioe_spi_master (.sck_o(sck), .cs_n_o(cs_n), .si_o(si),
        .so_i(so), .so_oe_i(so_oe));
    oioe_core #(.WIDTH(8)) u_oioe_core (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .ext_rst_n_i(ext_rst_n_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .so_o(so),
        .so_oe_o(so_oe), .hw_addr_0_i(hw_addr[0]), .hw_addr_1_i(hw_addr[1]),
        .hw_addr_2_i(hw_addr[2]), .addr3_mode_i(addr3_mode_i), .port_pin_i(port_pin_i),
        .port_pin_o(port_pin_o), .port_pin_oe_o(port_pin_oe_o),
        .pullup_en_o(pullup_en_o), .irq_o(irq_o), .irq_oe_o(irq_oe_o),
        .sck_too_fast_o(too_fast));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_oioe_spi_master.frame({4'h4, dev, 1'b0}, a, d, rd);
    endtask
    task automatic rdr(input logic [7:0] a, input logic [7:0] exp);
        u_oioe_spi_master.frame({4'h4, dev, 1'b1}, a, 8'h00, rd);
        chk("register", exp, rd);
    endtask
    task automatic irq_is(input logic [1:0] e);
        chk("irq pin", {6'h00, e}, {6'h00, irq_o, irq_oe_o});
    endtask
    task automatic pins(input logic [7:0] v);
        @(posedge clk_i);
        port_pin_i <= v;
        repeat (10) @(posedge clk_i);
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #400us;
        failures++;
        $display("watchdog expired");
        end_sim;
    end
    initial begin
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("drivers", 8'h00, port_pin_oe_o);
        irq_is(2'b11);
        for (int a = 0; a < 11; a++) rdr(a[7:0], a == 0 ? 8'hff : 8'h00);
        $display("test reset done");
        wr(8'h09, 8'h55);
        wr(8'h00, 8'h0f);
        chk("latch", 8'h55, port_pin_o);
        chk("drivers", 8'hf0, port_pin_oe_o);
        rdr(8'h0a, 8'h55);
        wr(8'h00, 8'hff);
        pins(8'ha3);
        wr(8'h01, 8'h0f);
        rdr(8'h09, 8'hac);
        wr(8'h01, 8'h00);
        rdr(8'h09, 8'ha3);
        wr(8'h06, 8'h3c);
        chk("pullup", 8'h3c, pullup_en_o);
        $display("test port done");
        wr(8'h05, 8'h02);
        irq_is(2'b01);
        wr(8'h02, 8'h01);
        pins(8'ha2);
        irq_is(2'b11);
        rdr(8'h07, 8'h01);
        irq_is(2'b11);
        rdr(8'h08, 8'ha2);
        irq_is(2'b01);
        chk("pullup", 8'h3c, pullup_en_o);
        $display("test change done");
        wr(8'h05, 8'h04);
        irq_is(2'b00);
        wr(8'h03, 8'h02);
        wr(8'h04, 8'h02);
        wr(8'h02, 8'h02);
        irq_is(2'b00);
        pins(8'ha0);
        irq_is(2'b01);
        rdr(8'h07, 8'h02);
        rdr(8'h08, 8'ha0);
        pins(8'ha2);
        rdr(8'h09, 8'ha2);
        irq_is(2'b00);
        $display("test compare done");
        rdr(8'h0c, 8'h00);
        dev = 3'h1;
        wr(8'h0a, 8'hee);
        chk("latch", 8'h55, port_pin_o);
        @(posedge clk_i);
        addr3_mode_i <= 1'b0;
        wr(8'h0a, 8'h33);
        chk("latch", 8'h33, port_pin_o);
        wr(8'h00, 8'h00);
        chk("drivers", 8'hff, port_pin_oe_o);
        $display("test address done");
        @(posedge clk_i);
        ext_rst_n_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        ext_rst_n_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk("drivers", 8'h00, port_pin_oe_o);
        chk("latch", 8'h00, port_pin_o);
        chk("pullup", 8'h00, pullup_en_o);
        rdr(8'h00, 8'hff);
        wr(8'h02, 8'h01);
        pins(8'ha3);
        irq_is(2'b01);
        rdr(8'h08, 8'ha3);
        irq_is(2'b11);
        chk("too fast", 8'h00, {7'h00, too_fast});
        $display("test external reset done");
        end_sim;
    end
endmodule // tb_top
`default_nettype wire
